// file: design/cswd_top.sv
// Purpose: Front end of the parallel configuration port: hunts for the
//          sync word and picks an 8- or 16-bit bus from its byte order.
// Assumes: Pins change with config_clock, which runs during reset.
// Notes:   Pin-facing logic runs on config_clock; words cross by toggle.
// Function
// - Bus width found from data alone
// - AA 99 55 66 on low lane: 8-bit
// - Low lane 99 then 66: 16-bit
// - Nothing forwarded before full sync
// - Sync is AA995566; pads never match
// - After first stream, discard further data
// - Bit swap undone within both bytes
module cswd_top (
  input wire logic core_clk,             // Core clock, 20 MHz
  input wire logic srst,                 // Synchronous reset, high
  input wire logic config_clock,         // Configuration link clock
  input wire logic [15:0] cfg_data_pins, // Parallel data pins
  input wire logic cfg_strobe,           // Sender word valid, high
  output logic cfg_busy,                 // Sender must hold off, high
  input wire logic config_done,          // First stream complete, high
  output logic out_valid,                // Word available
  input wire logic out_ready,            // Receiver takes word
  output logic [15:0] out_data,          // Unswapped word
  output logic out_wide,                 // Word is 16 bits
  output logic sync_found,               // Sync word recognised
  output logic bus_is_16,                // Detected width is 16
  output logic overrun                   // Word lost while busy
);
  // Link domain
  logic lrst_s1;
  logic link_rst;
  logic done_s1;
  logic done_s2;
  logic ack_s1;
  logic ack_s2;
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;
  cswd_pkg::cswd_state_t state_reg;
  cswd_pkg::cswd_state_t state_next;
  cswd_pkg::cswd_state_t hunt_next;
  logic locked;
  logic wide;
  logic discard_reg;
  logic word_push;
  logic busy;
  logic req_tgl_reg;
  logic [15:0] hold_data_reg;
  logic hold_wide_reg;
  logic overrun_reg;

  // Core domain
  logic req_s1;
  logic req_s2;
  logic lock_s1;
  logic lock_s2;
  logic wide_s1;
  logic wide_s2;
  logic ovr_s1;
  logic ovr_s2;
  logic ack_tgl_reg;
  logic req_pend;

  cswd_buf_if #(.W(cswd_pkg::BUF_W)) push_if ();
  cswd_buf_if #(.W(cswd_pkg::BUF_W)) pop_if ();

  // Reset and level crossings into the link domain
  always_ff @(posedge config_clock) begin
    lrst_s1 <= srst;
    link_rst <= lrst_s1;
  end

  always_ff @(posedge config_clock) begin
    done_s1 <= config_done;
    done_s2 <= done_s1;
  end

  always_ff @(posedge config_clock) begin
    ack_s1 <= ack_tgl_reg;
    ack_s2 <= ack_s1;
  end

  // Undo the bit swap per byte lane
  assign lo_byte = cswd_pkg::cswd_bitrev(cfg_data_pins[7:0]);
  assign hi_byte = cswd_pkg::cswd_bitrev(cfg_data_pins[15:8]);

  // Restart point for any byte that breaks a partial match
  always_comb begin
    if (lo_byte == cswd_pkg::SYNC_B3) begin
      hunt_next = cswd_pkg::ST_8_AA;
    end else if (lo_byte == cswd_pkg::SYNC_B2) begin
      hunt_next = cswd_pkg::ST_16_99;
    end else begin
      hunt_next = cswd_pkg::ST_HUNT;
    end
  end

  // Width is taken from the byte order only
  always_comb begin
    state_next = state_reg;
    if (cfg_strobe) begin
      case (state_reg)
        cswd_pkg::ST_HUNT: begin
          state_next = hunt_next;
        end
        cswd_pkg::ST_8_AA: begin
          if (lo_byte == cswd_pkg::SYNC_B2) begin
            state_next = cswd_pkg::ST_8_99;
          end else begin
            state_next = hunt_next;
          end
        end
        cswd_pkg::ST_8_99: begin
          if (lo_byte == cswd_pkg::SYNC_B1) begin
            state_next = cswd_pkg::ST_8_55;
          end else begin
            state_next = hunt_next;
          end
        end
        cswd_pkg::ST_8_55: begin
          if (lo_byte == cswd_pkg::SYNC_B0) begin
            state_next = cswd_pkg::ST_LOCK8;
          end else begin
            state_next = hunt_next;
          end
        end
        cswd_pkg::ST_16_99: begin
          if (lo_byte == cswd_pkg::SYNC_B0) begin
            state_next = cswd_pkg::ST_LOCK16;
          end else begin
            state_next = hunt_next;
          end
        end
        cswd_pkg::ST_LOCK8, cswd_pkg::ST_LOCK16: begin
          state_next = state_reg;
        end
        default: begin
          state_next = cswd_pkg::ST_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge config_clock) begin
    if (link_rst) begin
      state_reg <= cswd_pkg::ST_HUNT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign locked = state_reg == cswd_pkg::ST_LOCK8 ||
                  state_reg == cswd_pkg::ST_LOCK16;
  assign wide = state_reg == cswd_pkg::ST_LOCK16;

  // Once the first stream is complete, everything after it is dropped
  always_ff @(posedge config_clock) begin
    if (link_rst) begin
      discard_reg <= 1'b0;
    end else if (done_s2 && locked) begin
      discard_reg <= 1'b1;
    end
  end

  // Only words after the sync word go on
  assign word_push = locked && cfg_strobe && !discard_reg && !done_s2;
  assign busy = req_tgl_reg != ack_s2;
  assign cfg_busy = busy;

  // Word handed to the core domain by toggle request and toggle ack
  always_ff @(posedge config_clock) begin
    if (link_rst) begin
      req_tgl_reg <= 1'b0;
      hold_data_reg <= cswd_pkg::HOLD_RST;
      hold_wide_reg <= 1'b0;
    end else if (word_push && !busy) begin
      req_tgl_reg <= !req_tgl_reg;
      hold_wide_reg <= wide;
      if (wide) begin
        hold_data_reg <= {hi_byte, lo_byte};
      end else begin
        hold_data_reg <= {cswd_pkg::ZERO_BYTE, lo_byte};
      end
    end
  end

  // A word that arrives while the hand-over is busy is lost and flagged
  always_ff @(posedge config_clock) begin
    if (link_rst) begin
      overrun_reg <= 1'b0;
    end else if (word_push && busy) begin
      overrun_reg <= 1'b1;
    end
  end

  // Crossings into the core domain
  always_ff @(posedge core_clk) begin
    req_s1 <= req_tgl_reg;
    req_s2 <= req_s1;
    lock_s1 <= locked;
    lock_s2 <= lock_s1;
    wide_s1 <= wide;
    wide_s2 <= wide_s1;
    ovr_s1 <= overrun_reg;
    ovr_s2 <= ovr_s1;
  end

  // Hold register is stable while a request is pending
  assign req_pend = req_s2 != ack_tgl_reg;
  assign push_if.valid = req_pend;
  assign push_if.data = {hold_wide_reg, hold_data_reg};

  // Ack only when the buffer takes the word, so stalls reach the sender
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_tgl_reg <= 1'b0;
    end else if (req_pend && push_if.ready) begin
      ack_tgl_reg <= !ack_tgl_reg;
    end
  end

  cswd_buf #(
    .W(cswd_pkg::BUF_W),
    .DEPTH(cswd_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .srst(srst),
    .up(push_if),
    .dn(pop_if)
  );

  assign pop_if.ready = out_ready;
  assign out_valid = pop_if.valid;
  assign out_data = pop_if.data[cswd_pkg::DATA_W-1:0];
  assign out_wide = pop_if.data[cswd_pkg::WIDE_BIT];
  assign sync_found = lock_s2;
  assign bus_is_16 = wide_s2;
  assign overrun = ovr_s2;

  // Checks on the link side, plus a stall cover on the core side
  width_from_data_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    $rose(locked) |-> wide == ($past(state_reg) == cswd_pkg::ST_16_99))
    else $error("width does not follow byte order");

  lock8_seq_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    state_reg == cswd_pkg::ST_8_55 && cfg_strobe &&
    lo_byte == cswd_pkg::SYNC_B0 |=> locked && !wide)
    else $error("8-bit sync not locked");

  lock16_seq_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    state_reg == cswd_pkg::ST_16_99 && cfg_strobe &&
    lo_byte == cswd_pkg::SYNC_B0 |=> locked && wide)
    else $error("16-bit sync not locked");

  no_early_word_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    !locked |=> $stable(req_tgl_reg) && $stable(hold_data_reg))
    else $error("word passed before sync");

  pad_no_sync_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    state_reg == cswd_pkg::ST_HUNT && cfg_strobe &&
    cfg_data_pins[7:0] == cswd_pkg::PAD_BYTE |=>
    state_reg == cswd_pkg::ST_HUNT)
    else $error("pad word taken as sync");

  discard_tail_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    discard_reg |=> $stable(req_tgl_reg) && discard_reg)
    else $error("data after first stream passed");

  lane_swap_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    word_push && !busy && wide |=>
    hold_data_reg == {cswd_pkg::cswd_bitrev($past(cfg_data_pins[15:8])),
                      cswd_pkg::cswd_bitrev($past(cfg_data_pins[7:0]))})
    else $error("byte lanes not unswapped");

  width_hold_a: assert property (
    @(posedge config_clock) disable iff (link_rst)
    locked |=> locked && $stable(wide))
    else $error("width changed without reset");

  reset_hunt_a: assert property (
    @(posedge config_clock) link_rst |=> state_reg == cswd_pkg::ST_HUNT)
    else $error("reset did not restart hunt");

  lock8_c: cover property (@(posedge config_clock) disable iff (link_rst)
    $rose(locked) && !wide);
  lock16_c: cover property (@(posedge config_clock) disable iff (link_rst)
    $rose(locked) && wide);
  overrun_c: cover property (@(posedge config_clock) disable iff (link_rst)
    $rose(overrun_reg));
  stall_c: cover property (@(posedge core_clk) disable iff (srst)
    req_pend && !push_if.ready);
endmodule

// file: design/cswd_pkg.sv
// Purpose: Shared constants and types of the configuration sync and
//          bus-width detector.
// Assumes: Byte values are given in stored bitstream order.
// Notes:   Lane bytes on the pins arrive bit-swapped and are reversed
//          with cswd_bitrev before comparison.
package cswd_pkg;

  // Sync word, most significant byte first
  localparam logic [7:0] SYNC_B3 = 8'haa;
  localparam logic [7:0] SYNC_B2 = 8'h99;
  localparam logic [7:0] SYNC_B1 = 8'h55;
  localparam logic [7:0] SYNC_B0 = 8'h66;
  localparam logic [7:0] PAD_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam int DATA_W = 16;
  localparam int BUF_W = DATA_W + 1;
  localparam int BUF_DEPTH = 2;
  localparam int WIDE_BIT = 16;

  // Values after reset
  localparam logic [DATA_W-1:0] HOLD_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_8_AA,
    ST_8_99,
    ST_8_55,
    ST_16_99,
    ST_LOCK8,
    ST_LOCK16
  } cswd_state_t;

  // Undo the per-byte bit swap of the parallel pins
  function automatic logic [7:0] cswd_bitrev(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

endpackage

// file: design/cswd_buf_if.sv
// Purpose: Valid/ready word channel between the detector's own modules.
// Assumes: Word is taken on a clock edge where valid and ready are high.
// Notes:   One instance per direction of a buffer.
interface cswd_buf_if #(
  parameter int W = cswd_pkg::BUF_W
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: design/cswd_buf.sv
// Purpose: Small flip-flop FIFO that absorbs receiver stalls.
// Assumes: DEPTH is a power of two, at least two.
// Notes:   Ready on the fill side drops only when every entry is used.
module cswd_buf #(
  parameter int W = cswd_pkg::BUF_W,
  parameter int DEPTH = cswd_pkg::BUF_DEPTH
) (
  input wire logic core_clk, // Core clock
  input wire logic srst,     // Synchronous reset, high
  cswd_buf_if.snk up,        // Fill side
  cswd_buf_if.src dn         // Drain side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  if (W < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_cfg
    $error("cswd_buf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_push;
  logic do_pop;

  assign up.ready = count_reg != FULL_CNT;
  assign dn.valid = count_reg != '0;
  assign dn.data = mem[rd_ptr_reg];
  assign do_push = up.valid && up.ready;
  assign do_pop = dn.valid && dn.ready;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk) begin
      if (srst) begin
        mem[i] <= '0;
      end else if (do_push && wr_ptr_reg == AW'(i)) begin
        mem[i] <= up.data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_reg <= '0;
    end else if (do_push && !do_pop) begin
      count_reg <= count_reg + CW'(1);
    end else if (do_pop && !do_push) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  full_stall_a: assert property (@(posedge core_clk) disable iff (srst)
    count_reg == FULL_CNT && !dn.ready |=>
    count_reg == FULL_CNT && wr_ptr_reg == rd_ptr_reg)
    else $error("buffer accepts while full");

  keep_word_a: assert property (@(posedge core_clk) disable iff (srst)
    dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
    else $error("stalled word changed or vanished");

  buf_full_c: cover property (@(posedge core_clk) disable iff (srst)
    count_reg == FULL_CNT);
endmodule

// file: sim/cswd_host_model.sv
// Purpose: Sender model driving the parallel configuration pins.
// Assumes: Bytes are given in stored bitstream order.
// Notes:   Released pins float high through their pull-ups.
module cswd_host_model (
  input wire logic config_clock,     // Link clock
  input wire logic cfg_busy,         // Detector busy, high
  output logic [15:0] cfg_data_pins, // Parallel data pins
  output logic cfg_strobe            // Word valid, high
);
  timeunit 1ns;
  timeprecision 100ps;

  function automatic logic [7:0] swap(input logic [7:0] b);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction

  initial begin
    cfg_data_pins = 16'hffff;
    cfg_strobe = 1'b0;
  end

  // One word; ignore_busy pushes into a busy detector
  task automatic send(input logic [7:0] hi, input logic [7:0] lo,
                      input bit ignore_busy = 1'b0);
    int n;
    n = 0;
    @(posedge config_clock);
    #1;
    while (!ignore_busy && cfg_busy !== 1'b0 && n < 400) begin
      @(posedge config_clock);
      #1;
      n++;
    end
    cfg_data_pins = {swap(hi), swap(lo)};
    cfg_strobe = 1'b1;
    @(posedge config_clock);
    #1;
    cfg_strobe = 1'b0;
    cfg_data_pins = 16'hffff;
  endtask

  task automatic send_pads(input int n);
    repeat (n) send(8'hff, 8'hff);
  endtask

  task automatic send_sync(input bit wide);
    if (wide) begin
      send(cswd_pkg::SYNC_B3, cswd_pkg::SYNC_B2);
      send(cswd_pkg::SYNC_B1, cswd_pkg::SYNC_B0);
    end else begin
      send(8'hff, cswd_pkg::SYNC_B3);
      send(8'hff, cswd_pkg::SYNC_B2);
      send(8'hff, cswd_pkg::SYNC_B1);
      send(8'hff, cswd_pkg::SYNC_B0);
    end
  endtask
endmodule

// file: sim/cswd_top_tb.sv
// Purpose: Self-checking bench of the sync and bus-width detector.
// Assumes: Host model paces words on cfg_busy unless told otherwise.
// Notes:   Rows cover both widths; stall, overrun and done follow.
module cswd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic wide;
    logic broken;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] exp;
  } cswd_row_t;

  logic core_clk, srst, config_clock, cfg_strobe, cfg_busy, config_done;
  logic out_valid, out_ready, out_wide, sync_found, bus_is_16, overrun;
  logic [15:0] cfg_data_pins;
  logic [15:0] out_data;
  int failures = 0;
  int tests_run = 0;
  cswd_row_t rows [4] = '{
    '{1'b0, 1'b0, 8'hff, 8'h3c, 16'h003c},
    '{1'b1, 1'b0, 8'ha5, 8'hc3, 16'ha5c3},
    '{1'b0, 1'b1, 8'h81, 8'h01, 16'h0001},
    '{1'b1, 1'b1, 8'h0f, 8'he7, 16'h0fe7}
  };

  cswd_top u_cswd_top (.core_clk(core_clk), .srst(srst),
    .config_clock(config_clock), .cfg_data_pins(cfg_data_pins),
    .cfg_strobe(cfg_strobe), .cfg_busy(cfg_busy),
    .config_done(config_done), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_wide(out_wide),
    .sync_found(sync_found), .bus_is_16(bus_is_16), .overrun(overrun));

  cswd_host_model u_cswd_host_model (.config_clock(config_clock),
    .cfg_busy(cfg_busy), .cfg_data_pins(cfg_data_pins),
    .cfg_strobe(cfg_strobe));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    config_clock = 1'b0;
    #17.3;
    forever #62.5 config_clock = ~config_clock;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Link side needs several of its own edges to see reset
  task automatic do_reset();
    @(posedge core_clk);
    #1 srst = 1'b1;
    repeat (6) @(posedge config_clock);
    @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge config_clock);
    @(posedge core_clk);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic take(input logic [15:0] exp, input logic wide);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (out_valid !== 1'b1 && n < 200);
    check({16'h0000, out_valid}, 17'h00001);
    check({out_wide, out_data}, {wide, exp});
    out_ready = 1'b1;
    @(posedge core_clk);
    #1 out_ready = 1'b0;
  endtask

  initial begin
    srst = 1'b1;
    config_done = 1'b0;
    out_ready = 1'b0;
    foreach (rows[i]) begin
      do_reset();
      u_cswd_host_model.send_pads(2);
      u_cswd_host_model.send(8'h12, 8'h34);
      if (rows[i].broken) begin
        u_cswd_host_model.send(8'hff, 8'haa);
        u_cswd_host_model.send(8'hff, 8'h99);
        u_cswd_host_model.send(8'hff, 8'h12);
      end
      idle(20);
      check({16'h0000, out_valid}, 17'h00000);
      check({14'h0000, sync_found, bus_is_16, overrun}, 17'h0);
      u_cswd_host_model.send_sync(rows[i].wide);
      u_cswd_host_model.send(rows[i].hi, rows[i].lo);
      take(rows[i].exp, rows[i].wide);
      check({15'h0000, sync_found, bus_is_16},
            {15'h0000, 1'b1, rows[i].wide});
    end
    // Buffer full plus held word, then one pushed while busy
    u_cswd_host_model.send(8'h11, 8'h22);
    u_cswd_host_model.send(8'h33, 8'h44);
    u_cswd_host_model.send(8'haa, 8'h99);
    idle(20);
    check({15'h0000, cfg_busy, out_valid}, 17'h00003);
    u_cswd_host_model.send(8'h77, 8'h88, 1'b1);
    idle(10);
    check({16'h0000, overrun}, 17'h00001);
    take(16'h1122, 1'b1);
    take(16'h3344, 1'b1);
    take(16'haa99, 1'b1);
    idle(40);
    check({16'h0000, out_valid}, 17'h00000);
    config_done = 1'b1;
    idle(4);
    u_cswd_host_model.send(8'h9a, 8'hbc);
    idle(40);
    check({16'h0000, out_valid}, 17'h00000);
    // Done released again: the tail must still be dropped
    config_done = 1'b0;
    idle(8);
    u_cswd_host_model.send(8'h5a, 8'h3c);
    idle(40);
    check({16'h0000, out_valid}, 17'h00000);
    do_reset();
    idle(4);
    check({14'h0000, sync_found, bus_is_16, overrun}, 17'h0);
    final_report();
  end

  initial begin
    #500000;
    failures++;
    final_report();
  end
endmodule
